/* src/rail_regs_pkg.sv */
// Package with register map, field layout and timing constants of the discharge and delay bank.
package rail_regs_pkg;

  // Register offsets on the internal register port.
  localparam logic [7:0] DISCH_B_OFFSET = 8'h41;
  localparam logic [7:0] DISCH_C_OFFSET = 8'h42;
  localparam logic [7:0] PG_DELAY_OFFSET = 8'h43;

  // Field positions.
  localparam int AUX_LDO_TWO_LSB = 6;
  localparam int SWITCH_A_ONE_LSB = 4;
  localparam int BUCK_SIX_LSB = 2;
  localparam int BUCK_FIVE_LSB = 0;
  localparam int SWITCH_B_TWO_LSB = 4;
  localparam int SWITCH_B_ONE_LSB = 2;
  localparam int AUX_LDO_THREE_LSB = 0;
  localparam int DELAY_LSB = 0;

  // Writable masks; reserved bits read as zero.
  localparam logic [7:0] DISCH_B_MASK = 8'hFF;
  localparam logic [7:0] DISCH_C_MASK = 8'h3F;
  localparam logic [7:0] PG_DELAY_MASK = 8'h07;

  // Reset values.
  localparam logic [7:0] DISCH_B_RESET = 8'h00;
  localparam logic [7:0] DISCH_C_RESET = 8'h15;
  localparam logic [7:0] PG_DELAY_RESET = 8'h00;

  // Discharge resistance codes.
  typedef enum logic [1:0] {
    DISCH_NONE = 2'h0,
    DISCH_100 = 2'h1,
    DISCH_200 = 2'h2,
    DISCH_500 = 2'h3
  } discharge_code_t;

  // Output pin modes.
  localparam logic [1:0] MODE_POWER_GOOD = 2'h0;
  localparam logic [1:0] MODE_LEVEL_SHIFT = 2'h1;
  localparam logic [1:0] MODE_I2C_GPO = 2'h2;

  // Delay times in microseconds, and clock rate.
  localparam longint CLK_HZ = 200000000;
  localparam longint DELAY_US [8] = '{2500, 5000, 10000, 15000, 20000, 50000, 75000, 100000};
  // Half-millisecond tick length in microseconds, and its count of clock cycles.
  localparam longint TICK_US = 500;
  localparam int TICK_CYCLES = int'(CLK_HZ * TICK_US / 1000000);

  // Rail count on the enable and discharge buses.
  localparam int NUM_RAILS = 7;

  // Register port request bundle.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // Discharge selector bundle handed to the analog resistors.
  typedef struct packed {
    discharge_code_t aux_ldo_two_discharge_sel;
    discharge_code_t switch_a_one_discharge_sel;
    discharge_code_t buck_six_discharge_sel;
    discharge_code_t buck_five_discharge_sel;
    discharge_code_t switch_b_two_discharge_sel;
    discharge_code_t switch_b_one_discharge_sel;
    discharge_code_t aux_ldo_three_discharge_sel;
  } discharge_bus_t;

endpackage

/* src/pg_delay_timer.sv */
// Power-good delay timer counting half-millisecond ticks up to the programmed delay.
`timescale 1ns/10ps
`default_nettype none
module pg_delay_timer
  import rail_regs_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Control
  input wire logic start,
  input wire logic [2:0] code,
  // Result
  output logic expired
);

  // A prescaler shorter than one cycle cannot count a tick.
  if (TICK_LEN < 1)
  begin : g_bad_tick
    $error("TICK_LEN must be at least one cycle");
  end

  logic [$clog2(TICK_LEN+1)-1:0] pre_r;
  logic [7:0] ticks_r;
  logic [7:0] target;

  // Delay target in ticks of 0.5 ms.
  always_comb
  begin
    target = 8'(DELAY_US[code] / TICK_US);
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pre_r <= '0;
      ticks_r <= 8'h00;
      expired <= 1'b0;
    end
    else if (!start)
    begin
      pre_r <= '0;
      ticks_r <= 8'h00;
      expired <= 1'b0;
    end
    else if (!expired)
    begin
      if (ticks_r >= target)
      begin
        expired <= 1'b1;
      end
      else if (pre_r == ($clog2(TICK_LEN+1))'(TICK_LEN - 1))
      begin
        pre_r <= '0;
        ticks_r <= ticks_r + 8'h01;
      end
      else
      begin
        pre_r <= pre_r + ($clog2(TICK_LEN+1))'(1);
      end
    end
  end

endmodule
`default_nettype wire

/* src/rail_discharge_pg_delay_regs.sv */
// Discharge selector and power-good delay register bank.
//
// What this block does
// RULE1 - Bits 7:6 of register B pick second aux LDO discharge: none,100,200,500.
// RULE2 - Bits 5:4 of register B pick switch A one discharge resistance.
// RULE3 - Bits 3:2 of register B pick buck six discharge resistance.
// RULE4 - Bits 1:0 of register B pick buck five discharge resistance.
// RULE5 - Register C at 42h bits 5:4 pick switch B two discharge.
// RULE6 - Register C bits 3:2 pick switch B one discharge resistance.
// RULE7 - Register C bits 1:0 pick third aux LDO discharge resistance.
// RULE8 - An enabled rail always gets discharge code 00, whatever was written.
// RULE9 - Delay starts when all assigned rails regulate; power-good asserts on expiry.
// RULE10 - Output three is power-good, level shifter, or I2C-driven general output; mode code 3 drives it low.
// RULE11 - Delay codes 0..7 give 2.5,5,10,15,20,50,75,100 ms.
// RULE12 - Delay bits are ignored when output is I2C-driven and not used for termination.
// RULE13 - Reserved bits read zero and ignore writes.
`timescale 1ns/10ps
`default_nettype none
module rail_discharge_pg_delay_regs
  import rail_regs_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES,
  parameter int RAILS = NUM_RAILS
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register port from the serial interface
  input wire reg_req_t req,
  output logic [7:0] rdata,
  // Rail enables, bit order as in discharge_bus_t, MSB first
  input wire logic [RAILS-1:0] rail_enable,
  // Output three configuration
  input wire logic [1:0] out_mode,
  input wire logic termination_enable_use,
  input wire logic in_regulation,
  input wire logic level_in,
  input wire logic gpo_level,
  // Results
  output discharge_bus_t discharge,
  output logic general_output_three,
  output logic power_good
);

  // ***********************************
  // Parameter checks
  // ***********************************
  // The field layout is fixed by the package, so a different rail count cannot be served.
  if (RAILS != NUM_RAILS)
  begin : g_bad_rails
    $error("RAILS must match the number of discharge fields");
  end
  if (2 * RAILS != $bits(discharge_bus_t))
  begin : g_bad_bus
    $error("RAILS must give two bits per field of the discharge bus");
  end

  // ***********************************
  // Registers
  // ***********************************
  logic [7:0] disch_b_r;
  logic [7:0] disch_c_r;
  logic [7:0] delay_r;

  // Each register keeps its writable bits only, so reserved bits stay zero.
  // A read and a write on the same edge return the value from before the write.
  // RULE13 reserved write mask
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      disch_b_r <= DISCH_B_RESET;
      disch_c_r <= DISCH_C_RESET;
      delay_r <= PG_DELAY_RESET;
    end
    else if (req.wr)
    begin
      if (req.addr == DISCH_B_OFFSET)
      begin
        disch_b_r <= req.wdata & DISCH_B_MASK;
      end
      if (req.addr == DISCH_C_OFFSET)
      begin
        disch_c_r <= req.wdata & DISCH_C_MASK;
      end
      if (req.addr == PG_DELAY_OFFSET)
      begin
        delay_r <= req.wdata & PG_DELAY_MASK;
      end
    end
  end

  logic [7:0] rdata_nxt;

  // Unmapped offsets read as zero.
  // RULE13 reserved reads zero
  always_comb
  begin
    unique case (req.addr)
      DISCH_B_OFFSET: rdata_nxt = disch_b_r;
      DISCH_C_OFFSET: rdata_nxt = disch_c_r & DISCH_C_MASK;
      PG_DELAY_OFFSET: rdata_nxt = delay_r & PG_DELAY_MASK;
      default: rdata_nxt = 8'h00;
    endcase
  end

  // Read data hold until the next read strobe.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rdata <= 8'h00;
    end
    else if (req.rd)
    begin
      rdata <= rdata_nxt;
    end
  end

  // ***********************************
  // Discharge selectors
  // ***********************************
  logic [2*RAILS-1:0] stored;
  logic [2*RAILS-1:0] forced;

  // RULE1 RULE2 RULE3 RULE4 register B fields
  // RULE5 RULE6 RULE7 register C fields
  always_comb
  begin
    stored = {disch_b_r[AUX_LDO_TWO_LSB +: 2], disch_b_r[SWITCH_A_ONE_LSB +: 2],
              disch_b_r[BUCK_SIX_LSB +: 2], disch_b_r[BUCK_FIVE_LSB +: 2],
              disch_c_r[SWITCH_B_TWO_LSB +: 2], disch_c_r[SWITCH_B_ONE_LSB +: 2],
              disch_c_r[AUX_LDO_THREE_LSB +: 2]};
  end

  genvar g;
  generate
    for (g = 0; g < RAILS; g++)
    begin : g_rail
      // The force sits ahead of the output register, so the resistors see the
      // forced code one cycle after the rail comes on.
      // RULE8 force none when enabled
      assign forced[2*g +: 2] = rail_enable[g] ? DISCH_NONE : stored[2*g +: 2];
    end
  endgenerate

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      discharge <= '0;
    end
    else
    begin
      discharge <= discharge_bus_t'(forced);
    end
  end

  // ***********************************
  // Output three and power-good delay
  // ***********************************
  logic delay_used;
  logic expired;

  // Under software control with no termination duty the timer stays cleared,
  // so a stale delay code cannot raise power-good.
  // RULE12 delay ignored when unused
  assign delay_used = (out_mode != MODE_I2C_GPO) || termination_enable_use;

  // RULE9 RULE11 delay from regulation
  pg_delay_timer #(
    .TICK_LEN(TICK_LEN)
  ) u_timer (
    .mclk(mclk),
    .rst(rst),
    .start(in_regulation && delay_used),
    .code(delay_r[DELAY_LSB +: 3]),
    .expired(expired)
  );

  // Power-good drops the cycle after regulation is lost, without waiting for the timer.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      power_good <= 1'b0;
    end
    else
    begin
      power_good <= expired && in_regulation;
    end
  end

  logic out_three_nxt;

  // RULE10 output mode select
  always_comb
  begin
    unique case (out_mode)
      MODE_POWER_GOOD: out_three_nxt = expired && in_regulation;
      MODE_LEVEL_SHIFT: out_three_nxt = expired && level_in;
      MODE_I2C_GPO: out_three_nxt = gpo_level;
      default: out_three_nxt = 1'b0;
    endcase
  end

  // The pin level is registered so that it cannot glitch while the mode changes.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      general_output_three <= 1'b0;
    end
    else
    begin
      general_output_three <= out_three_nxt;
    end
  end

endmodule
`default_nettype wire

/* verification/rail_regs_assertions.sv */
// Checker of the discharge and delay register bank.
`timescale 1ns/10ps
`default_nettype none
module rail_regs_assertions
  import rail_regs_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES,
  parameter int RAILS = NUM_RAILS
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Watched ports
  input wire reg_req_t req,
  input wire logic [7:0] rdata,
  input wire logic [RAILS-1:0] rail_enable,
  input wire logic [1:0] out_mode,
  input wire logic in_regulation,
  input wire logic gpo_level,
  input wire discharge_bus_t discharge,
  input wire logic general_output_three,
  input wire logic power_good
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_gpo_held;
    out_mode == MODE_I2C_GPO ##1 out_mode == MODE_I2C_GPO;
  endsequence
  AST_ON_NONE: assert property (&rail_enable |=> discharge == '0)
    else $error("enabled rails kept a discharge code");
  AST_LDO2_ON: assert property (rail_enable[6] |=> discharge.aux_ldo_two_discharge_sel == DISCH_NONE)
    else $error("enabled rail kept a discharge code");
  AST_C_RSVD: assert property (req.rd && req.addr == DISCH_C_OFFSET |=> rdata[7:6] == 2'h0)
    else $error("reserved bits of register C read nonzero");
  AST_D_RSVD: assert property (req.rd && req.addr == PG_DELAY_OFFSET |=> rdata[7:3] == 5'h00)
    else $error("reserved bits of delay register read nonzero");
  AST_PG_DROP: assert property (!in_regulation |=> !power_good)
    else $error("power good high without regulation");
  AST_PG_WAIT: assert property ($rose(in_regulation) |=> !power_good [*4])
    else $error("power good rose before the delay");
  AST_GPO: assert property (s_gpo_held |-> general_output_three == $past(gpo_level))
    else $error("output three does not follow its level");
  AST_LOW_MODE: assert property (out_mode == 2'h3 |=> !general_output_three)
    else $error("output three not low in low mode");
endmodule
bind rail_discharge_pg_delay_regs rail_regs_assertions #(.TICK_LEN(TICK_LEN), .RAILS(RAILS)) chk (
  .mclk(mclk), .rst(rst), .req(req), .rdata(rdata), .rail_enable(rail_enable),
  .out_mode(out_mode), .in_regulation(in_regulation), .gpo_level(gpo_level),
  .discharge(discharge), .general_output_three(general_output_three), .power_good(power_good));
`default_nettype wire

/* verification/rail_discharge_pg_delay_regs_tb_top.sv */
// Testbench of the discharge and delay register bank.
`timescale 1ns/10ps
`default_nettype none
module rail_discharge_pg_delay_regs_tb_top;
  import rail_regs_pkg::*;
  localparam int TB_TICK = 4;
  logic mclk, rst, in_regulation, gpo_level, general_output_three, power_good;
  logic termination_use, level_in;
  reg_req_t req;
  logic [7:0] rdata;
  logic [6:0] rail_enable;
  logic [1:0] out_mode;
  discharge_bus_t discharge;
  int error_cnt, compares;
  rail_discharge_pg_delay_regs #(.TICK_LEN(TB_TICK)) dut (
    .mclk(mclk), .rst(rst), .req(req), .rdata(rdata), .rail_enable(rail_enable),
    .out_mode(out_mode), .termination_enable_use(termination_use), .in_regulation(in_regulation),
    .level_in(level_in), .gpo_level(gpo_level), .discharge(discharge),
    .general_output_three(general_output_three), .power_good(power_good));
  task automatic chk(input string name, input logic [13:0] exp, input logic [13:0] got);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic stop_test;
    if (error_cnt == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk);
    req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge mclk);
    req <= '0;
    #1;
    chk("rdata", {6'h00, e}, {6'h00, rdata});
  endtask
  task automatic settle(input logic [13:0] e);
    repeat (3) @(posedge mclk);
    #1;
    chk("discharge", e, discharge);
  endtask
  task automatic t_regs;
    rd(DISCH_B_OFFSET, 8'h00);
    rd(DISCH_C_OFFSET, 8'h15);
    rd(PG_DELAY_OFFSET, 8'h00);
    rd(8'h44, 8'h00);
    wr(DISCH_C_OFFSET, 8'hFF);
    wr(PG_DELAY_OFFSET, 8'hFF);
    rd(DISCH_C_OFFSET, 8'h3F);
    rd(PG_DELAY_OFFSET, 8'h07);
  endtask
  task automatic t_fields;
    wr(DISCH_B_OFFSET, 8'h1B);
    wr(DISCH_C_OFFSET, 8'hDB);
    settle(14'h06DB);
    wr(DISCH_B_OFFSET, 8'hE4);
    rd(DISCH_C_OFFSET, 8'h1B);
    settle(14'h391B);
    @(posedge mclk);
    rail_enable <= 7'h55;
    settle(14'h0808);
    @(posedge mclk);
    rail_enable <= 7'h2A;
    settle(14'h3113);
    @(posedge mclk);
    rail_enable <= 7'h7F;
    settle(14'h0000);
    @(posedge mclk);
    rail_enable <= 7'h00;
    settle(14'h391B);
  endtask
  task automatic t_delay;
    int n;
    int e;
    for (int c = 0; c < 8; c++)
    begin
      wr(PG_DELAY_OFFSET, 8'hF8 | c[7:0]);
      e = int'(DELAY_US[c] / TICK_US) * TB_TICK;
      @(posedge mclk);
      in_regulation <= 1'b1;
      n = 0;
      while (power_good !== 1'b1 && n < e + 20)
      begin
        @(posedge mclk);
        #1;
        n++;
      end
      chk("pg_wait", 14'h0001, {13'h0000, n >= e - e / 10 && n <= e + e / 10 + 3});
      chk("gpo_pg", 14'h0001, {13'h0000, general_output_three});
      if (power_good !== 1'b1)
      begin
        error_cnt++;
        $display("MISMATCH pg_timeout expected 1 seen %b", power_good);
        stop_test;
      end
      @(posedge mclk);
      in_regulation <= 1'b0;
      repeat (2) @(posedge mclk);
      #1;
      chk("pg_drop", 14'h0000, {13'h0000, power_good});
    end
  endtask
  task automatic t_modes;
    wr(PG_DELAY_OFFSET, 8'h00);
    @(posedge mclk);
    out_mode <= MODE_LEVEL_SHIFT;
    level_in <= 1'b1;
    in_regulation <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    chk("shift_early", 14'h0000, {13'h0000, general_output_three});
    repeat (30) @(posedge mclk);
    #1;
    chk("shift_high", 14'h0001, {13'h0000, general_output_three});
    @(posedge mclk);
    level_in <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    chk("shift_low", 14'h0000, {13'h0000, general_output_three});
    @(posedge mclk);
    in_regulation <= 1'b0;
    out_mode <= MODE_I2C_GPO;
    gpo_level <= 1'b0;
    @(posedge mclk);
    in_regulation <= 1'b1;
    repeat (30) @(posedge mclk);
    #1;
    chk("pg_ignored", 14'h0000, {13'h0000, power_good});
    @(posedge mclk);
    termination_use <= 1'b1;
    repeat (30) @(posedge mclk);
    #1;
    chk("pg_term", 14'h0001, {13'h0000, power_good});
    @(posedge mclk);
    in_regulation <= 1'b0;
    termination_use <= 1'b0;
    out_mode <= MODE_POWER_GOOD;
  endtask
  task automatic t_gpo;
    @(posedge mclk);
    out_mode <= MODE_I2C_GPO;
    gpo_level <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    chk("gpo_high", 14'h0001, {13'h0000, general_output_three});
    @(posedge mclk);
    gpo_level <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    chk("gpo_low", 14'h0000, {13'h0000, general_output_three});
    @(posedge mclk);
    out_mode <= 2'h3;
    gpo_level <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    chk("low_mode", 14'h0000, {13'h0000, general_output_three});
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  initial
  begin
    rst = 1'b1;
    req = '0;
    rail_enable = 7'h00;
    out_mode = MODE_POWER_GOOD;
    in_regulation = 1'b0;
    gpo_level = 1'b0;
    termination_use = 1'b0;
    level_in = 1'b0;
    error_cnt = 0;
    compares = 0;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    t_regs;
    t_fields;
    t_delay;
    t_modes;
    t_gpo;
    stop_test;
  end
endmodule
`default_nettype wire
